// file: design/csfr_identity.sv
// Builds the hardwired identity word from its field parameters.
// Assumes parameters hold legal codes; the value is constant after elaboration.
`timescale 1ns/10ps
`default_nettype none

module csfr_identity #(
    parameter logic [4:0] REVISION = 5'h00,
    parameter logic [3:0] PROGRAM_STORE_CAPACITY = csfr_pkg::PSC_NONE,
    parameter logic [3:0] NV_DATA_CAPACITY = csfr_pkg::NVD_NONE,
    parameter logic [3:0] RAM_CAPACITY = csfr_pkg::RAM_8K,
    parameter logic [7:0] FAMILY_CODE = 8'h00,
    parameter logic [2:0] PROGRAM_STORE_KIND = csfr_pkg::PSK_SERIES_A,
    parameter logic ID_CONTINUATION_FLAG = 1'h0
)(
    output logic [31:0] identity_word
);

    ////////////////////////////////////////////////////////////////////////////
    // Field placement
    // Each field sits at its fixed position so software can decode it blindly
    always_comb
    begin
        identity_word = 32'h0000_0000;
        identity_word[csfr_pkg::POS_REVISION +: 5] = REVISION;
        identity_word[csfr_pkg::POS_FIXED_PATTERN +: 3] = csfr_pkg::FIXED_PATTERN;
        identity_word[csfr_pkg::POS_PROGRAM_STORE_CAPACITY +: 4] = PROGRAM_STORE_CAPACITY;
        identity_word[csfr_pkg::POS_NV_DATA_CAPACITY +: 4] = NV_DATA_CAPACITY;
        identity_word[csfr_pkg::POS_RAM_CAPACITY +: 4] = RAM_CAPACITY;
        identity_word[csfr_pkg::POS_FAMILY_CODE +: 8] = FAMILY_CODE;
        identity_word[csfr_pkg::POS_PROGRAM_STORE_KIND +: 3] = PROGRAM_STORE_KIND;
        identity_word[csfr_pkg::POS_ID_CONTINUATION_FLAG] = ID_CONTINUATION_FLAG;
    end

endmodule

`default_nettype wire

// file: design/csfr_pkg.sv
// Constants for the chip special-function register bank.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock domain.
package csfr_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CHIP_IDENTITY = 8'h00;
    localparam logic [7:0] OFS_IDENTITY_ADDENDUM = 8'h04;
    localparam logic [7:0] OFS_RESET_CAUSE = 8'h08;
    localparam logic [7:0] OFS_PROTECTION_MODE = 8'h18;
    localparam int ADDR_W = 8;

    // Identity word field positions
    localparam int POS_REVISION = 0;
    localparam int POS_FIXED_PATTERN = 5;
    localparam int POS_PROGRAM_STORE_CAPACITY = 8;
    localparam int POS_NV_DATA_CAPACITY = 12;
    localparam int POS_RAM_CAPACITY = 16;
    localparam int POS_FAMILY_CODE = 20;
    localparam int POS_PROGRAM_STORE_KIND = 28;
    localparam int POS_ID_CONTINUATION_FLAG = 31;

    // Fixed bits 7:5 of the identity word read as 010
    localparam logic [2:0] FIXED_PATTERN = 3'h2;

    // Program store capacity codes
    localparam logic [3:0] PSC_NONE = 4'h0;
    localparam logic [3:0] PSC_32K = 4'h3;
    localparam logic [3:0] PSC_64K = 4'h5;
    localparam logic [3:0] PSC_128K = 4'h7;
    localparam logic [3:0] PSC_256K = 4'h9;

    // Nonvolatile data capacity: only none is defined
    localparam logic [3:0] NVD_NONE = 4'h0;

    // RAM capacity codes, one-hot except RAM_NONE at zero
    localparam logic [3:0] RAM_NONE = 4'h0;
    localparam logic [3:0] RAM_1K = 4'h1;
    localparam logic [3:0] RAM_2K = 4'h2;
    localparam logic [3:0] RAM_4K = 4'h4;
    localparam logic [3:0] RAM_8K = 4'h8;

    // Program store kinds
    localparam logic [2:0] PSK_SERIES_A = 3'h1;
    localparam logic [2:0] PSK_SERIES_B = 3'h4;

    // Reset cause codes
    localparam logic [7:0] CAUSE_PIN = 8'h6C;
    localparam logic [7:0] CAUSE_WATCHDOG = 8'h53;

    // Protection mode register layout
    localparam logic [15:0] WRITE_UNLOCK_KEY = 16'h27A8;
    localparam int POS_KEY = 16;
    localparam int POS_GUARD = 5;
    localparam logic PMODE_RESET = 1'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: design/csfr_top.sv
// Special-function register bank: identity, extension, reset cause, protection mode.
// One AXI4-Lite slave port reaches a hardwired identity word, a latched reset cause
// and a key-guarded mode bit that steers the interrupt controller.
// Assumes an AXI4-Lite master on MCLK, and reset cause pins held steady across reset release.
// Assumes the cause level is settled before reset lifts and for three edges after it.
// Limitation: one read in flight, a further read waits for the answer; a further write is taken but commits after the answer.
`timescale 1ns/10ps
`default_nettype none

module csfr_top #(
    parameter logic [4:0] REVISION = 5'h00,
    parameter logic [3:0] PROGRAM_STORE_CAPACITY = csfr_pkg::PSC_NONE,
    parameter logic [3:0] NV_DATA_CAPACITY = csfr_pkg::NVD_NONE,
    parameter logic [3:0] RAM_CAPACITY = csfr_pkg::RAM_8K,
    // Family code value is arbitrary, BCD digits 1 and 2
    parameter logic [7:0] FAMILY_CODE = 8'h12,
    parameter logic [2:0] PROGRAM_STORE_KIND = csfr_pkg::PSK_SERIES_A,
    parameter logic ID_CONTINUATION_FLAG = 1'h0
)(
    input wire logic MCLK,
    input wire logic RST_N,
    // Write address channel
    input wire logic [7:0] S_AXI_AWADDR,
    // Protection level is ignored: every access level sees the same registers
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // Write data channel
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // Write response channel
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // Read address channel
    input wire logic [7:0] S_AXI_ARADDR,
    // Ignored for the same reason as the write side
    input wire logic [2:0] S_AXI_ARPROT,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // Read data channel
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Reset cause indication from the reset controller, level
    // Crosses in from another domain, so it is synchronised before use
    input wire logic WATCHDOG_RESET_SEEN,
    // Interrupt controller mode select
    output logic INTERRUPT_GUARD_ENABLE
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    // Everything the block remembers lives in one record, so reset clears it in one go
    // and the next-state process can start from a full copy
    typedef struct packed {
        logic [7:0] awaddr;      // Captured write address
        logic aw_held;           // Write address captured
        logic [31:0] wdata;      // Captured write data
        logic [3:0] wstrb;       // Captured write strobes
        logic w_held;            // Write data captured
        logic bvalid;            // Write response pending
        logic [1:0] bresp;       // Write response code
        logic rvalid;            // Read data pending
        logic [31:0] rdata;      // Read data
        logic [1:0] rresp;       // Read response code
        logic wd_sync1;          // Watchdog cause sync, first stage
        logic wd_sync2;          // Watchdog cause sync, second stage
        logic primed1; // First edge after reset has passed
        logic primed2; // Second stage now holds a settled cause level
        logic cause_taken;       // Reset cause already latched
        logic [7:0] cause;       // Latched reset cause code
        logic guard;             // Interrupt guard mode bit
    } csfr_state_t;

    csfr_state_t state_reg;
    csfr_state_t state_next;
    logic [31:0] identity_word; // Hardwired identity value
    logic write_fire;           // Both write halves present, response free
    logic key_ok;               // Unlock key matches
    logic [31:0] read_word;     // Decoded read value
    logic [7:0] ar_word; // Read address with byte offset dropped
    logic [7:0] aw_word; // Held write address with byte offset dropped
    logic lanes_ok; // Key and guard byte lanes all enabled

    ////////////////////////////////////////////////////////////////////////////
    // Identity word
    // Pure wiring: the word is fixed at elaboration and costs no flip-flops
    csfr_identity #(
        .REVISION(REVISION),
        .PROGRAM_STORE_CAPACITY(PROGRAM_STORE_CAPACITY),
        .NV_DATA_CAPACITY(NV_DATA_CAPACITY),
        .RAM_CAPACITY(RAM_CAPACITY),
        .FAMILY_CODE(FAMILY_CODE),
        .PROGRAM_STORE_KIND(PROGRAM_STORE_KIND),
        .ID_CONTINUATION_FLAG(ID_CONTINUATION_FLAG)
    ) u_identity (
        .identity_word(identity_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address alignment and byte-lane check
    // The two low address bits are dropped, so a misaligned access lands on its word;
    // read decode, read response and write commit share these so they agree on the map
    always_comb
    begin
        ar_word = {S_AXI_ARADDR[7:2], 2'h0};
        aw_word = {state_reg.awaddr[7:2], 2'h0};
        // Key sits in lanes 3 and 2 and the guard bit in lane 0; all three must be written,
        // otherwise a partial write could flip the guard without the key being present
        lanes_ok = (state_reg.wstrb[3:2] == 2'h3) && state_reg.wstrb[0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read decode
    // Only the word address matters; unmapped offsets answer zero with SLVERR
    // Decode runs off the live address and is captured on the edge the address is taken,
    // so the word seen by software is the value at that edge
    always_comb
    begin
        read_word = 32'h0000_0000;
        case (ar_word)
            csfr_pkg::OFS_CHIP_IDENTITY:
            begin
                // Hardwired fields, nothing stored behind them
                read_word = identity_word;
            end
            csfr_pkg::OFS_IDENTITY_ADDENDUM:
            begin
                // Not yet defined, reads all zero
                read_word = 32'h0000_0000;
            end
            csfr_pkg::OFS_RESET_CAUSE:
            begin
                // Upper three bytes are reserved and read zero
                read_word = {24'h00_0000, state_reg.cause};
            end
            csfr_pkg::OFS_PROTECTION_MODE:
            begin
                // Key field always reads back zero
                // Only the guard bit is stored; every other bit reads zero
                read_word[csfr_pkg::POS_GUARD] = state_reg.guard;
            end
            default:
            begin
                // Reserved and unmapped words
                read_word = 32'h0000_0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    // Starts from a copy of the record so every field keeps its value unless a branch moves it
    always_comb
    begin
        state_next = state_reg;
        // Holding the commit back while a response waits keeps an unread answer from being overrun
        write_fire = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
        // Key compared on the held data, so a later WDATA change cannot slip past
        key_ok = (state_reg.wdata[csfr_pkg::POS_KEY +: 16] == csfr_pkg::WRITE_UNLOCK_KEY);

        // Synchroniser; only the second stage feeds logic
        // Input comes from the reset controller's domain, not from MCLK logic
        state_next.wd_sync1 = WATCHDOG_RESET_SEEN;
        state_next.wd_sync2 = state_reg.wd_sync1;

        // Two marker flops tell when the second stage holds the level seen after release
        state_next.primed1 = 1'h1;
        state_next.primed2 = state_reg.primed1;

        // Reset cause is caught once, on the third edge after release, from the second stage;
        // reading the first stage here would let a metastable level reach the cause register
        if (state_reg.primed2 && !state_reg.cause_taken)
        begin
            state_next.cause_taken = 1'h1;
            state_next.cause = state_reg.wd_sync2 ? csfr_pkg::CAUSE_WATCHDOG : csfr_pkg::CAUSE_PIN;
        end

        // Address and data may arrive in either order
        if (S_AXI_AWVALID && !state_reg.aw_held)
        begin
            // Address held; AWREADY drops until the commit
            state_next.aw_held = 1'h1;
            state_next.awaddr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !state_reg.w_held)
        begin
            // Data and strobes held; WREADY drops until the commit
            state_next.w_held = 1'h1;
            state_next.wdata = S_AXI_WDATA;
            state_next.wstrb = S_AXI_WSTRB;
        end

        // Commit a write once both halves are held
        if (write_fire)
        begin
            state_next.aw_held = 1'h0;
            state_next.w_held = 1'h0;
            // Both halves consumed; the answer shows on the next cycle
            state_next.bvalid = 1'h1;
            state_next.bresp = csfr_pkg::RESP_OKAY;
            case (aw_word)
                csfr_pkg::OFS_PROTECTION_MODE:
                begin
                    // Key lives in the top bytes, so those lanes must be written too;
                    // a refused write still answers OKAY, software reads back to confirm
                    if (key_ok && lanes_ok)
                    begin
                        // Bit 5 alone is stored; other data bits are dropped
                        state_next.guard = state_reg.wdata[csfr_pkg::POS_GUARD];
                    end
                end
                csfr_pkg::OFS_CHIP_IDENTITY,
                csfr_pkg::OFS_IDENTITY_ADDENDUM,
                csfr_pkg::OFS_RESET_CAUSE:
                begin
                    // Read-only words swallow writes silently
                    state_next.bresp = csfr_pkg::RESP_OKAY;
                end
                default:
                begin
                    // Nothing lives here; tell the master
                    state_next.bresp = csfr_pkg::RESP_SLVERR;
                end
            endcase
        end
        // Response stands until the master takes it
        if (state_reg.bvalid && S_AXI_BREADY)
        begin
            state_next.bvalid = 1'h0;
        end

        // Reads answer one edge after the address is taken
        // One read in flight: a new address is only taken once the last data has gone
        if (S_AXI_ARVALID && !state_reg.rvalid)
        begin
            state_next.rvalid = 1'h1;
            state_next.rdata = read_word;
            // Only the four defined words answer OKAY
            case (ar_word)
                csfr_pkg::OFS_CHIP_IDENTITY,
                csfr_pkg::OFS_IDENTITY_ADDENDUM,
                csfr_pkg::OFS_RESET_CAUSE,
                csfr_pkg::OFS_PROTECTION_MODE:
                begin
                    // Defined word, data already captured above
                    state_next.rresp = csfr_pkg::RESP_OKAY;
                end
                default:
                begin
                    // Reserved or unmapped word
                    state_next.rresp = csfr_pkg::RESP_SLVERR;
                end
            endcase
        end
        // Data stands until the master takes it
        else if (state_reg.rvalid && S_AXI_RREADY)
        begin
            state_next.rvalid = 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    // Asynchronous clear with constants only, so reset never waits on the clock;
    // the cause starts at the pin code so an early read still names a real cause
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_reg <= '0;
            state_reg.cause <= csfr_pkg::CAUSE_PIN;
            state_reg.guard <= csfr_pkg::PMODE_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    // Ready signals are simple holds: one item per channel until the write commits or the read data is taken
    // Readies are combinational from held flags; they never depend on a valid input,
    // so no loop through the master can form
    // Data and response outputs come straight from the record's flip-flops
    assign S_AXI_AWREADY = !state_reg.aw_held;
    assign S_AXI_WREADY = !state_reg.w_held;
    assign S_AXI_BVALID = state_reg.bvalid;
    assign S_AXI_BRESP = state_reg.bresp;
    assign S_AXI_ARREADY = !state_reg.rvalid;
    assign S_AXI_RVALID = state_reg.rvalid;
    assign S_AXI_RDATA = state_reg.rdata;
    assign S_AXI_RRESP = state_reg.rresp;
    assign INTERRUPT_GUARD_ENABLE = state_reg.guard;

endmodule

`default_nettype wire

// file: verification/csfr_props.sv
// Checker for the special-function register bank, top ports only.
// Assumes the default identity parameters; bound to every csfr_top.
`timescale 1ns/10ps
`default_nettype none

module csfr_props #(
    // Identity word for the default parameter set
    parameter logic [31:0] ID_WORD = 32'h11280040
)(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic INTERRUPT_GUARD_ENABLE
);
    // One clock domain; reset silences every check
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);

    ////////////////////////////////////////////////////////////
    // Read address taken at a word index
    sequence rd_at(int w);
        S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[7:2] == w;
    endsequence
    // Address and data taken on one edge
    sequence wr_both;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence

    ////////////////////////////////////////////////////////////
    id_word_a: assert property (rd_at(0) |=> S_AXI_RDATA == ID_WORD)
        else $error("identity word wrong");
    ext_zero_a: assert property (rd_at(1) |=> S_AXI_RDATA == 32'h0)
        else $error("extension word not zero");
    cause_code_a: assert property (rd_at(2) |=> S_AXI_RDATA inside {32'h6C, 32'h53})
        else $error("reset cause code wrong");
    pmode_read_a: assert property (rd_at(6) |=> S_AXI_RDATA == {26'h0, INTERRUPT_GUARD_ENABLE, 5'h0})
        else $error("mode register read wrong");
    // Reserved offsets answer with an error and no data
    unmapped_err_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY && !(S_AXI_ARADDR[7:2] inside {0, 1, 2, 6})
        |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
        else $error("reserved offset not refused");
    // Guard only moves on the edge a write commits
    guard_change_a: assert property ($changed(INTERRUPT_GUARD_ENABLE) |-> $rose(S_AXI_BVALID))
        else $error("guard changed without a write");
    read_answer_a: assert property (rd_at(0) or rd_at(6) |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read not answered");
    write_answer_a: assert property (wr_both |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
        else $error("write response late");
endmodule

bind csfr_top csfr_props u_props (.*);

`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the register bank over AXI4-Lite.
// Assumes default identity parameters and an always-ready response side.
`timescale 1ns/10ps
`default_nettype none

module testbench;
    // Bus signals carry the port names so the instance binds by name
    logic MCLK = 1'b0, RST_N = 1'b0, WATCHDOG_RESET_SEEN = 1'b0;
    logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
    logic [2:0] S_AXI_AWPROT = 3'h0, S_AXI_ARPROT = 3'h0;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB = 4'h0;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_ARVALID = 1'b0;
    // Answers are always accepted at once
    logic S_AXI_BREADY = 1'b1, S_AXI_RREADY = 1'b1;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic INTERRUPT_GUARD_ENABLE;
    int n_tests = 0, n_mismatch = 0;
    // Read-only words and what they hold whatever is written
    logic [7:0] ro_a [3] = '{8'h00, 8'h04, 8'h08};
    logic [31:0] ro_d [3] = '{32'h11280040, 32'h0, 32'h6C};
    // Reserved and unmapped offsets
    logic [7:0] um_a [5] = '{8'h0C, 8'h10, 8'h14, 8'h1C, 8'hFC};

    csfr_top dut (.*);

    // 200 MHz system clock
    always #2.5 MCLK = ~MCLK;

    ////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Reset with a chosen cause; cause held steady afterwards
    task automatic reset_dut(input logic wd);
        WATCHDOG_RESET_SEEN <= wd;
        RST_N <= 1'b0;
        repeat (2) @(posedge MCLK);
        RST_N <= 1'b1;
        repeat (4) @(posedge MCLK);
    endtask

    // Write: address and data offered together, each released when taken
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_d, w_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= s;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        while (!(aw_d && w_d))
        begin
            @(posedge MCLK);
            aw_d = aw_d || S_AXI_AWREADY === 1'b1;
            w_d = w_d || S_AXI_WREADY === 1'b1;
            if (aw_d) S_AXI_AWVALID <= 1'b0;
            if (w_d) S_AXI_WVALID <= 1'b0;
        end
        do @(posedge MCLK); while (S_AXI_BVALID !== 1'b1);
        // Every mapped write answers OKAY, ignored or not
        chk({30'h0, S_AXI_BRESP}, 32'h0);
    endtask

    // Read: address held until taken, data taken with the answer
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        do @(posedge MCLK); while (S_AXI_ARREADY !== 1'b1);
        S_AXI_ARVALID <= 1'b0;
        do @(posedge MCLK); while (S_AXI_RVALID !== 1'b1);
        chk(S_AXI_RDATA, ed);
        chk({30'h0, S_AXI_RRESP}, {30'h0, er});
    endtask

    // Counts, verdict and end of run
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        reset_dut(1'b0);
        rd_chk(8'h00, 32'h11280040, 2'h0);
        rd_chk(8'h04, 32'h0, 2'h0);
        rd_chk(8'h08, 32'h6C, 2'h0);
        rd_chk(8'h18, 32'h0, 2'h0);
        // Writes to read-only words leave them unchanged
        foreach (ro_a[i])
        begin
            wr_chk(ro_a[i], 32'hFFFFFFFF, 4'hF);
            rd_chk(ro_a[i], ro_d[i], 2'h0);
        end
        foreach (um_a[i]) rd_chk(um_a[i], 32'h0, 2'h2);
        // Wrong key, then right key with a lane missing: both ignored
        wr_chk(8'h18, 32'h27A90020, 4'hF);
        chk({31'h0, INTERRUPT_GUARD_ENABLE}, 32'h0);
        wr_chk(8'h18, 32'h27A80020, 4'hB);
        chk({31'h0, INTERRUPT_GUARD_ENABLE}, 32'h0);
        wr_chk(8'h18, 32'h27A80020, 4'hF);
        chk({31'h0, INTERRUPT_GUARD_ENABLE}, 32'h1);
        rd_chk(8'h18, 32'h20, 2'h0);
        // Keyed write with the bit low returns to normal mode
        wr_chk(8'h18, 32'h27A80000, 4'hF);
        chk({31'h0, INTERRUPT_GUARD_ENABLE}, 32'h0);
        wr_chk(8'h18, 32'h27A80020, 4'hF);
        chk({31'h0, INTERRUPT_GUARD_ENABLE}, 32'h1);
        // Unkeyed write of zero must not clear the guard
        wr_chk(8'h18, 32'h00000000, 4'hF);
        chk({31'h0, INTERRUPT_GUARD_ENABLE}, 32'h1);
        // Watchdog reset in mid-run clears the guard and changes the cause
        reset_dut(1'b1);
        rd_chk(8'h08, 32'h53, 2'h0);
        rd_chk(8'h18, 32'h0, 2'h0);
        chk({31'h0, INTERRUPT_GUARD_ENABLE}, 32'h0);
        wrap_up();
    end

    // Hang guard: the tests need under a hundred cycles
    initial
    begin
        repeat (3000) @(posedge MCLK);
        n_mismatch++;
        wrap_up();
    end
endmodule

`default_nettype wire
